// ===== verilog/irq_ctrl_map.svh
// constants of the prioritised interrupt controller: offsets, fields, vectors, timing
// assumes inclusion by bare name from the top module and the test bench
// How it works
// - external pins active low, level or edge
// - edge flag cleared when cpu vectors
// - level flag follows the pin directly
// - reset 0x0000, sources 0x0003 plus eight each
// - only externals, two timers, network auto-clear
// - per-source priority bit, low after reset
// - high preempts low, high never preempted
// - high level wins over low level
// - equal level: lowest index wins
// - per-source enable and priority bits
// - decode every clock, best response five cycles
// - one instruction after return before vectoring
// - worst response eighteen cycles without blocking
// - equal or lower waits past return plus one
// - global enable gates every request
// - flag still set after return re-enters
// - software-set flag requests like hardware, except external flags in level mode
`ifndef IRQ_CTRL_MAP_SVH
`define IRQ_CTRL_MAP_SVH

// register byte offsets
`define REG_CTRL 12'h000
`define REG_ENABLE 12'h004
`define REG_PRIORITY 12'h008
`define REG_PEND_SET 12'h00c
`define REG_PEND_CLR 12'h010
`define REG_STATE 12'h014
`define REG_IRQ_STATUS 12'h018
`define REG_IRQ_CLEAR 12'h01c
`define REG_IRQ_ENABLE 12'h020

// control fields
`define CTRL_GEN_BIT 0
`define CTRL_EDGE_A_BIT 1
`define CTRL_EDGE_B_BIT 2
`define CTRL_RESET 3'h0

// state fields
`define ST_ACT_LOW_BIT 0
`define ST_ACT_HIGH_BIT 1
`define ST_REQ_BIT 2
`define ST_HOLD_BIT 3
`define ST_IDX_LSB 8

// event bits
`define EVT_VECTOR_BIT 0
`define EVT_PREEMPT_BIT 1
`define EVT_W 2

// source indices and auto-clear set
`define SRC_EXT_A 0
`define SRC_EXT_B 2
`define AUTOCLR_MASK 32'h0008000f

// vectors
`define RESET_VECTOR 16'h0000
`define VEC_BASE 16'h0003
`define VEC_SHIFT 3

// response timing in cycles
`define DETECT_CYCLES 1
`define LCALL_CYCLES 4
`define BEST_RESPONSE 5
`define WORST_RESPONSE 18

`endif

// ===== verilog/irq_ctrl_pkg.sv
// types shared by the interrupt controller modules
// assumes the map header is on the include path
package irq_ctrl_pkg;
	typedef enum logic {LVL_LOW, LVL_HIGH} level_t;
	typedef logic [31:0] word_t;
endpackage : irq_ctrl_pkg

// ===== verilog/pick_if.sv
// request vector and winner between the top module and a priority picker
// assumes one clock domain; carries combinational values only
`timescale 1ns/1ps
`default_nettype none
interface pick_if #(parameter int N = 22, parameter int W = 5);
	logic [N-1:0] req;
	logic found;
	logic [W-1:0] idx;
	modport picker (input req, output found, output idx);
	modport user (output req, input found, input idx);
endinterface : pick_if
`default_nettype wire

// ===== verilog/ext_pin_detect.sv
// detector for one active-low external interrupt pin
// assumes the pin is already synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module ext_pin_detect (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// pin and mode
	input wire logic pin_n,
	input wire logic edge_sel,
	// results
	output logic fall_evt,
	output logic level_active
);
	logic prev_r;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prev_r <= 1'b1;
		end else begin
			prev_r <= pin_n;
		end
	end

	assign fall_evt = edge_sel & prev_r & ~pin_n;
	assign level_active = ~pin_n;
endmodule : ext_pin_detect
`default_nettype wire

// ===== verilog/priority_picker.sv
// fixed-order picker: lowest set index of the request vector wins
// assumes a combinational path inside one clock cycle
`timescale 1ns/1ps
`default_nettype none
module priority_picker #(parameter int N = 22, parameter int W = 5) (
	// request and winner
	pick_if.picker p
);
	generate
		if (N < 1 || W < $clog2(N)) begin : g_bad_param
			$error("W too narrow for N");
		end
	endgenerate

	always_comb begin
		p.found = 1'b0;
		p.idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (p.req[i]) begin
				p.found = 1'b1;
				p.idx = W'(i);
			end
		end
	end
endmodule : priority_picker
`default_nettype wire

// ===== verilog/prioritised_interrupt_controller.sv
// two-level interrupt controller with pending flags, apb registers and vector request
// assumes an apb master, a cpu sequencer giving completion pulses, synchronous pins
//
// The register addresses and the APB interface to the registers were left to the implementer.
`include "irq_ctrl_map.svh"
`timescale 1ns/1ps
`default_nettype none
module prioritised_interrupt_controller #(
	parameter int NUM_SRC = 22,
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// external interrupt pins
	input wire logic ext_irq_pin_a_n,
	input wire logic ext_irq_pin_b_n,
	// peripheral flag set pulses
	input wire logic [NUM_SRC-1:0] src_event,
	// cpu sequencer
	input wire logic instr_done,
	input wire logic reti_done,
	input wire logic vec_ack,
	output logic vec_req,
	output logic [15:0] vec_addr,
	output logic [$clog2(NUM_SRC)-1:0] vec_index,
	output logic vec_level,
	// flag views
	output logic [NUM_SRC-1:0] pending_flags,
	output logic [NUM_SRC-1:0] auto_clear,
	// interrupt
	output logic irq
);
	localparam int IDX_W = $clog2(NUM_SRC);
	localparam logic [31:0] AUTOCLR_ALL = `AUTOCLR_MASK;
	localparam logic [NUM_SRC-1:0] AUTOCLR = AUTOCLR_ALL[NUM_SRC-1:0];

	generate
		if (NUM_SRC < 20 || NUM_SRC > 32 || ADDR_W < 12) begin : g_bad_param
			$error("NUM_SRC must be 20..32 and ADDR_W at least 12");
		end
	endgenerate

	// registers
	logic gen_r;
	logic edge_a_r;
	logic edge_b_r;
	logic [NUM_SRC-1:0] enable_r;
	logic [NUM_SRC-1:0] prio_r;
	logic [NUM_SRC-1:0] pend_r;
	logic [NUM_SRC-1:0] pend_nxt;
	logic [NUM_SRC-1:0] autoclr_r;
	logic act_low_r;
	logic act_high_r;
	logic hold_r;
	logic vec_req_r;
	logic [IDX_W-1:0] vec_idx_r;
	irq_ctrl_pkg::level_t vec_lvl_r;
	logic [15:0] vec_addr_r;
	logic [`EVT_W-1:0] irq_stat_r;
	logic [`EVT_W-1:0] irq_en_r;
	logic irq_r;
	irq_ctrl_pkg::word_t prdata_r;
	logic pready_r;
	logic pslverr_r;

	// apb decode
	logic setup_phase;
	logic wr_fire;
	logic addr_ok;
	logic [11:0] addr;
	irq_ctrl_pkg::word_t rd_data;

	assign addr = paddr[11:0];
	assign setup_phase = psel & ~penable;
	assign wr_fire = psel & penable & pready_r & pwrite;

	always_comb begin
		rd_data = '0;
		addr_ok = 1'b1;
		case (addr)
			`REG_CTRL: begin
				rd_data[`CTRL_GEN_BIT] = gen_r;
				rd_data[`CTRL_EDGE_A_BIT] = edge_a_r;
				rd_data[`CTRL_EDGE_B_BIT] = edge_b_r;
			end
			`REG_ENABLE: begin
				rd_data[NUM_SRC-1:0] = enable_r;
			end
			`REG_PRIORITY: begin
				rd_data[NUM_SRC-1:0] = prio_r;
			end
			`REG_PEND_SET: begin
				rd_data[NUM_SRC-1:0] = pend_r;
			end
			`REG_PEND_CLR: begin
				rd_data = '0;
			end
			`REG_STATE: begin
				rd_data[`ST_ACT_LOW_BIT] = act_low_r;
				rd_data[`ST_ACT_HIGH_BIT] = act_high_r;
				rd_data[`ST_REQ_BIT] = vec_req_r;
				rd_data[`ST_HOLD_BIT] = hold_r;
				rd_data[`ST_IDX_LSB +: IDX_W] = vec_idx_r;
			end
			`REG_IRQ_STATUS: begin
				rd_data[`EVT_W-1:0] = irq_stat_r;
			end
			`REG_IRQ_CLEAR: begin
				rd_data = '0;
			end
			`REG_IRQ_ENABLE: begin
				rd_data[`EVT_W-1:0] = irq_en_r;
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
	end

	// answer one cycle after setup
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= '0;
		end else begin
			pready_r <= setup_phase & ~pready_r;
			if (setup_phase) begin
				pslverr_r <= ~addr_ok;
				prdata_r <= pwrite ? '0 : rd_data;
			end
		end
	end

	// software-written register strobes
	logic wr_ctrl;
	logic wr_en;
	logic wr_prio;
	logic [NUM_SRC-1:0] sw_set;
	logic [NUM_SRC-1:0] sw_clr;
	logic [`EVT_W-1:0] evt_clr;

	assign wr_ctrl = wr_fire & (addr == `REG_CTRL);
	assign wr_en = wr_fire & (addr == `REG_ENABLE);
	assign wr_prio = wr_fire & (addr == `REG_PRIORITY);
	assign sw_set = (wr_fire & (addr == `REG_PEND_SET)) ? pwdata[NUM_SRC-1:0] : '0;
	assign sw_clr = (wr_fire & (addr == `REG_PEND_CLR)) ? pwdata[NUM_SRC-1:0] : '0;
	assign evt_clr = (wr_fire & (addr == `REG_IRQ_CLEAR)) ? pwdata[`EVT_W-1:0] : '0;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			{edge_b_r, edge_a_r, gen_r} <= `CTRL_RESET;
		end else if (wr_ctrl) begin
			gen_r <= pwdata[`CTRL_GEN_BIT];
			edge_a_r <= pwdata[`CTRL_EDGE_A_BIT];
			edge_b_r <= pwdata[`CTRL_EDGE_B_BIT];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			enable_r <= '0;
		end else if (wr_en) begin
			enable_r <= pwdata[NUM_SRC-1:0];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prio_r <= '0;
		end else if (wr_prio) begin
			prio_r <= pwdata[NUM_SRC-1:0];
		end
	end

	// external pins
	logic fall_a;
	logic fall_b;
	logic lvl_a;
	logic lvl_b;

	ext_pin_detect u_ext_a (
		.core_clk(core_clk),
		.rst(rst),
		.pin_n(ext_irq_pin_a_n),
		.edge_sel(edge_a_r),
		.fall_evt(fall_a),
		.level_active(lvl_a)
	);

	ext_pin_detect u_ext_b (
		.core_clk(core_clk),
		.rst(rst),
		.pin_n(ext_irq_pin_b_n),
		.edge_sel(edge_b_r),
		.fall_evt(fall_b),
		.level_active(lvl_b)
	);

	// vector acceptance
	logic take;
	logic [NUM_SRC-1:0] take_onehot;

	assign take = vec_ack & vec_req_r;
	assign take_onehot = take ? (NUM_SRC'(1) << vec_idx_r) : '0;

	// pending flags: set wins over clear
	always_comb begin
		logic [NUM_SRC-1:0] hw_set;
		logic [NUM_SRC-1:0] clr;
		hw_set = '0;
		clr = '0;
		hw_set = src_event | sw_set;
		hw_set[`SRC_EXT_A] = fall_a | sw_set[`SRC_EXT_A];
		hw_set[`SRC_EXT_B] = fall_b | sw_set[`SRC_EXT_B];
		clr = sw_clr | (take_onehot & AUTOCLR);
		pend_nxt = hw_set | (pend_r & ~clr);
		if (!edge_a_r) begin
			pend_nxt[`SRC_EXT_A] = lvl_a;
		end
		if (!edge_b_r) begin
			pend_nxt[`SRC_EXT_B] = lvl_b;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pend_r <= '0;
		end else begin
			pend_r <= pend_nxt;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			autoclr_r <= '0;
		end else begin
			autoclr_r <= take_onehot & AUTOCLR;
		end
	end

	// arbitration
	pick_if #(.N(NUM_SRC), .W(IDX_W)) hi_p ();
	pick_if #(.N(NUM_SRC), .W(IDX_W)) lo_p ();
	logic [NUM_SRC-1:0] eligible;

	assign eligible = pend_r & enable_r & {NUM_SRC{gen_r}};
	assign hi_p.req = eligible & prio_r;
	assign lo_p.req = eligible & ~prio_r;

	priority_picker #(.N(NUM_SRC), .W(IDX_W)) u_pick_hi (
		.p(hi_p.picker)
	);

	priority_picker #(.N(NUM_SRC), .W(IDX_W)) u_pick_lo (
		.p(lo_p.picker)
	);

	logic cand;
	logic [IDX_W-1:0] cand_idx;
	irq_ctrl_pkg::level_t cand_lvl;
	logic blocked;

	assign blocked = hold_r | reti_done;

	always_comb begin
		cand = 1'b0;
		cand_idx = '0;
		cand_lvl = irq_ctrl_pkg::LVL_LOW;
		if (hi_p.found && !act_high_r) begin
			cand = 1'b1;
			cand_idx = hi_p.idx;
			cand_lvl = irq_ctrl_pkg::LVL_HIGH;
		end else if (lo_p.found && !act_high_r && !act_low_r) begin
			cand = 1'b1;
			cand_idx = lo_p.idx;
			cand_lvl = irq_ctrl_pkg::LVL_LOW;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hold_r <= 1'b0;
		end else if (reti_done) begin
			hold_r <= 1'b1;
		end else if (instr_done) begin
			hold_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			vec_req_r <= 1'b0;
			vec_idx_r <= '0;
			vec_lvl_r <= irq_ctrl_pkg::LVL_LOW;
		end else begin
			vec_req_r <= cand & ~blocked & ~take;
			if (cand) begin
				vec_idx_r <= cand_idx;
				vec_lvl_r <= cand_lvl;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			vec_addr_r <= `RESET_VECTOR;
		end else if (cand) begin
			vec_addr_r <= `VEC_BASE + (16'(cand_idx) << `VEC_SHIFT);
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			act_low_r <= 1'b0;
			act_high_r <= 1'b0;
		end else begin
			if (reti_done) begin
				if (act_high_r) begin
					act_high_r <= 1'b0;
				end else begin
					act_low_r <= 1'b0;
				end
			end
			if (take && vec_lvl_r == irq_ctrl_pkg::LVL_HIGH) begin
				act_high_r <= 1'b1;
			end
			if (take && vec_lvl_r == irq_ctrl_pkg::LVL_LOW) begin
				act_low_r <= 1'b1;
			end
		end
	end

	// status events, set wins over clear
	logic [`EVT_W-1:0] evt;

	always_comb begin
		evt = '0;
		evt[`EVT_VECTOR_BIT] = take;
		evt[`EVT_PREEMPT_BIT] = take & act_low_r & (vec_lvl_r == irq_ctrl_pkg::LVL_HIGH);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_stat_r <= '0;
		end else begin
			irq_stat_r <= evt | (irq_stat_r & ~evt_clr);
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_en_r <= '0;
		end else if (wr_fire && addr == `REG_IRQ_ENABLE) begin
			irq_en_r <= pwdata[`EVT_W-1:0];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(irq_stat_r & irq_en_r);
		end
	end

	// outputs
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign vec_req = vec_req_r;
	assign vec_addr = vec_addr_r;
	assign vec_index = vec_idx_r;
	assign vec_level = vec_lvl_r;
	assign pending_flags = pend_r;
	assign auto_clear = autoclr_r;
	assign irq = irq_r;
endmodule : prioritised_interrupt_controller
`default_nettype wire

// ===== bench/cpu_seq_model.sv
// cpu sequencer model: vector call acknowledge and return pulses
// assumes controller outputs registered on core_clk
`timescale 1ns/1ps
`default_nettype none
module cpu_seq_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// controller side
	input wire logic vec_req,
	output logic vec_ack,
	output logic instr_done,
	output logic reti_done,
	// bench control
	input wire logic slow,
	input wire logic go_reti
);
	logic [1:0] wait_r;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			vec_ack <= 1'b0;
			wait_r <= 2'h0;
		end else if (vec_req && !vec_ack && (!slow || wait_r == 2'h3)) begin
			vec_ack <= 1'b1;
		end else begin
			vec_ack <= 1'b0;
			wait_r <= (vec_req && !vec_ack) ? wait_r + 2'h1 : 2'h0;
		end
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reti_done <= 1'b0;
			instr_done <= 1'b0;
		end else begin
			reti_done <= go_reti;
			instr_done <= reti_done;
		end
	end
endmodule : cpu_seq_model
`default_nettype wire

// ===== bench/prioritised_interrupt_controller_checker.sv
// checker of vector, auto-clear and in-service behaviour
// assumes binding onto the controller top module
`timescale 1ns/1ps
`default_nettype none
module prioritised_interrupt_controller_checker #(parameter int NUM_SRC = 22) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// cpu side
	input wire logic reti_done,
	input wire logic vec_ack,
	input wire logic vec_req,
	input wire logic [15:0] vec_addr,
	input wire logic [$clog2(NUM_SRC)-1:0] vec_index,
	input wire logic vec_level,
	// flags
	input wire logic [NUM_SRC-1:0] pending_flags,
	input wire logic [NUM_SRC-1:0] auto_clear
);
	localparam logic [NUM_SRC-1:0] ac_mask = NUM_SRC'(32'h0008000f);
	logic hi_r;
	logic lo_r;
	logic [NUM_SRC-1:0] pend_r;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pend_r <= '0;
		end else begin
			pend_r <= pending_flags;
		end
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hi_r <= 1'b0;
			lo_r <= 1'b0;
		end else begin
			if (reti_done) begin
				if (hi_r) begin
					hi_r <= 1'b0;
				end else begin
					lo_r <= 1'b0;
				end
			end
			if (vec_ack && vec_req) begin
				if (vec_level) begin
					hi_r <= 1'b1;
				end else begin
					lo_r <= 1'b1;
				end
			end
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	a_vec_addr_map: assert property (vec_req |-> vec_addr == 16'h0003 + {vec_index, 3'h0})
		else $error("vector address off");
	a_clear_on_ack: assert property (vec_ack && vec_req |=>
		auto_clear == (ac_mask & (1 << $past(vec_index)))) else $error("auto clear wrong");
	a_clear_only_set: assert property ((auto_clear & ~ac_mask) == '0)
		else $error("auto clear outside set");
	a_clear_cause: assert property (|auto_clear |-> $past(vec_ack && vec_req))
		else $error("auto clear without vector");
	a_reti_hold: assert property (reti_done |=> !vec_req [*2])
		else $error("request too soon after return");
	a_ack_drop: assert property (vec_ack && vec_req |=> !vec_req)
		else $error("request stays after ack");
	a_high_locked: assert property (hi_r |-> !vec_req)
		else $error("high routine preempted");
	a_low_only_high: assert property (lo_r && vec_req |-> vec_level)
		else $error("equal level request in low routine");
	a_req_pending: assert property (vec_req |-> pend_r[vec_index])
		else $error("request without pending flag");
	c_preempt: cover property (lo_r && vec_ack && vec_req && vec_level);
	c_high_return: cover property (reti_done && hi_r);
	c_auto_clear: cover property (|auto_clear);
endmodule : prioritised_interrupt_controller_checker
bind prioritised_interrupt_controller prioritised_interrupt_controller_checker #(
	.NUM_SRC(NUM_SRC)) u_prioritised_interrupt_controller_checker (.core_clk, .rst,
	.reti_done, .vec_ack, .vec_req, .vec_addr, .vec_index, .vec_level, .pending_flags, .auto_clear);
`default_nettype wire

// ===== bench/prioritised_interrupt_controller_test.sv
// self-checking bench of the interrupt controller with a cpu sequencer model
// assumes the checker is bound from its own file
`include "irq_ctrl_map.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((e) !== (g)) begin fail_count++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
`define LOOK(nm, e, g) @(negedge core_clk); `CHK(nm, e, g) @(posedge core_clk);
module prioritised_interrupt_controller_test;
	logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, slow = 0, go_reti = 0;
	logic ext_irq_pin_a_n = 1, ext_irq_pin_b_n = 1, pready, pslverr, irq;
	logic instr_done, reti_done, vec_ack, vec_req, vec_level;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic [21:0] src_event = '0, pending_flags, auto_clear;
	logic [15:0] vec_addr;
	logic [4:0] vec_index;
	logic [32:0] exp_rd[$];
	logic [21:0] exp_vec[$];
	int fail_count = 0, n_compared = 0, cyc = 0, a;
	always #2.5 core_clk = ~core_clk;
	prioritised_interrupt_controller u_prioritised_interrupt_controller (.core_clk, .rst, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_irq_pin_a_n,
		.ext_irq_pin_b_n, .src_event, .instr_done, .reti_done, .vec_ack, .vec_req, .vec_addr,
		.vec_index, .vec_level, .pending_flags, .auto_clear, .irq);
	cpu_seq_model u_cpu_seq_model (.core_clk, .rst, .vec_req, .vec_ack, .instr_done, .reti_done,
		.slow, .go_reti);
	task automatic wrap_up;
		if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	function automatic logic [21:0] va(input int i, input logic l);
		return {l, 5'(i), 16'h0003 + 16'(i * 8)};
	endfunction : va
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		@(posedge core_clk iff pready);
		psel <= 0;
		penable <= 0;
		@(posedge core_clk);
	endtask : apb
	task automatic rd(input logic [11:0] ad, input logic [32:0] e);
		exp_rd.push_back(e);
		apb(0, ad, 0);
	endtask : rd
	task automatic wack;
		@(posedge core_clk iff (vec_ack && vec_req));
	endtask : wack
	task automatic isr(input logic [31:0] clr);
		apb(1, `REG_PEND_CLR, clr);
		go_reti <= 1;
		@(posedge core_clk);
		go_reti <= 0;
		slow <= 1'($urandom % 2);
	endtask : isr
	always @(posedge core_clk) begin
		logic [32:0] er;
		logic [21:0] ev;
		if (psel && penable && pready && !pwrite) begin
			er = exp_rd.size() ? exp_rd.pop_front() : '1;
			`CHK("prdata", er, {pslverr, prdata})
		end
		if (vec_ack && vec_req) begin
			ev = exp_vec.size() ? exp_vec.pop_front() : '1;
			`CHK("vector", ev, {vec_level, vec_index, vec_addr})
		end
		cyc++;
		if (cyc == 4000) begin
			fail_count++;
			wrap_up;
		end
	end
	initial begin
		void'($urandom(25));
		repeat (8) @(posedge core_clk);
		rst <= 0;
		@(posedge core_clk);
		rd(`REG_PRIORITY, 33'h0);
		rd(12'h0fc, 33'h100000000);
		apb(1, `REG_CTRL, 32'h7);
		apb(1, `REG_ENABLE, 32'h3fffff);
		a = 4 + $urandom % 8;
		exp_vec.push_back(va(a, 0));
		exp_vec.push_back(va(a + 5, 0));
		apb(1, `REG_PEND_SET, 32'h21 << a);
		wack;
		isr(32'h1 << a);
		wack;
		isr(32'h20 << a);
		apb(1, `REG_PRIORITY, 32'h5000);
		exp_vec.push_back(va(12, 1));
		exp_vec.push_back(va(4, 0));
		apb(1, `REG_PEND_SET, 32'h1010);
		wack;
		isr(32'h1000);
		wack;
		isr(32'h10);
		exp_vec.push_back(va(6, 0));
		apb(1, `REG_PEND_SET, 32'h40);
		wack;
		exp_vec.push_back(va(14, 1));
		src_event <= 22'h4000;
		@(posedge core_clk);
		src_event <= 22'h0;
		`LOOK("vec_req", 1'b0, vec_req)
		`LOOK("vec_req", 1'b1, vec_req)
		wack;
		apb(1, `REG_PEND_SET, 32'h1080);
		isr(32'h4000);
		exp_vec.push_back(va(12, 1));
		wack;
		isr(32'h1000);
		repeat (8) @(posedge core_clk);
		exp_vec.push_back(va(7, 0));
		isr(32'h40);
		wack;
		isr(32'h80);
		apb(1, `REG_CTRL, 32'h6);
		apb(1, `REG_PEND_SET, 32'h100);
		repeat (6) @(posedge core_clk);
		`LOOK("vec_req", 1'b0, vec_req)
		exp_vec.push_back(va(8, 0));
		apb(1, `REG_CTRL, 32'h7);
		wack;
		isr(32'h100);
		exp_vec.push_back(va(0, 0));
		ext_irq_pin_a_n <= 0;
		@(posedge core_clk);
		ext_irq_pin_a_n <= 1;
		wack;
		@(posedge core_clk);
		`LOOK("pending_a", 1'b0, pending_flags[0])
		isr(0);
		apb(1, `REG_CTRL, 32'h3);
		exp_vec.push_back(va(2, 0));
		ext_irq_pin_b_n <= 0;
		wack;
		ext_irq_pin_b_n <= 1;
		@(posedge core_clk);
		`LOOK("pending_b", 1'b0, pending_flags[2])
		isr(0);
		rd(`REG_IRQ_STATUS, 33'h3);
		`LOOK("irq", 1'b0, irq)
		apb(1, `REG_IRQ_ENABLE, 32'h1);
		`LOOK("irq", 1'b1, irq)
		apb(1, `REG_IRQ_CLEAR, 32'h3);
		rd(`REG_IRQ_STATUS, 33'h0);
		`LOOK("irq", 1'b0, irq)
		wrap_up;
	end
endmodule : prioritised_interrupt_controller_test
`default_nettype wire
